// *** logic/pgss_pkg.sv ***
// constants and types for the position gain switch selector
package pgss_pkg;
	// register byte offsets
	localparam logic [11:0] PGSS_OFS_MODE = 12'h000;
	localparam logic [11:0] PGSS_OFS_DELAY = 12'h004;
	localparam logic [11:0] PGSS_OFS_LEVEL = 12'h008;
	localparam logic [11:0] PGSS_OFS_HYST = 12'h00C;
	localparam logic [11:0] PGSS_OFS_STAT = 12'h010;
	// ranges and reset values
	localparam logic [3:0] PGSS_MODE_MAX = 4'hA;
	localparam logic [3:0] PGSS_MODE_RST = 4'h0;
	localparam logic [15:0] PGSS_DELAY_MAX = 16'h2710;
	localparam logic [15:0] PGSS_DELAY_RST = 16'h0032;
	localparam logic [15:0] PGSS_LEVEL_MAX = 16'h4E20;
	localparam logic [15:0] PGSS_LEVEL_RST = 16'h0032;
	localparam logic [15:0] PGSS_HYST_RST = 16'h0021;
	// switching conditions
	localparam logic [3:0] PGSS_M_FIX1 = 4'h0;
	localparam logic [3:0] PGSS_M_FIX2 = 4'h1;
	localparam logic [3:0] PGSS_M_INPUT = 4'h2;
	localparam logic [3:0] PGSS_M_TORQUE = 4'h3;
	localparam logic [3:0] PGSS_M_SPDVAR = 4'h4;
	localparam logic [3:0] PGSS_M_SPDCMD = 4'h5;
	localparam logic [3:0] PGSS_M_POSDEV = 4'h6;
	localparam logic [3:0] PGSS_M_POSCMD = 4'h7;
	localparam logic [3:0] PGSS_M_INPOS = 4'h8;
	localparam logic [3:0] PGSS_M_ACTSPD = 4'h9;
	localparam logic [3:0] PGSS_M_CMDSPD = 4'hA;
	// status field positions
	localparam int PGSS_ST_GAIN = 0;
	localparam int PGSS_ST_CNT = 16;
	// timing: one control cycle is 0.1 ms
	localparam int PGSS_CLK_NS = 5;
	localparam int PGSS_TICK_NS = 100000;
	localparam int PGSS_TICK_CYC = PGSS_TICK_NS / PGSS_CLK_NS;
	// active control loop
	typedef enum logic [1:0] {
		PGSS_CTL_POS,
		PGSS_CTL_VEL,
		PGSS_CTL_TRQ,
		PGSS_CTL_FULL
	} pgss_ctl_t;
	// gain state
	typedef enum logic {
		PGSS_GS_FIRST,
		PGSS_GS_SECOND
	} pgss_gs_t;
	// control loop quantities: five signed values, already scaled, and two single-bit flags
	typedef struct packed {
		logic signed [31:0] torque_cmd;
		logic signed [31:0] spd_cmd_var;
		logic signed [31:0] spd_cmd;
		logic signed [31:0] pos_dev;
		logic signed [31:0] act_spd;
		logic pos_cmd_nz;
		logic pos_done;
	} pgss_loop_t;
endpackage : pgss_pkg

// *** logic/pgss_selector.sv ***
// position gain switch selector with apb parameter registers
`timescale 1ns/100ps
`default_nettype none
module pgss_selector import pgss_pkg::*; #(
	parameter int TICK_CYC = PGSS_TICK_CYC
) (
	input wire logic I_MCLK,
	input wire logic I_NRST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic [1:0] I_CTRL_MODE,
	input wire logic I_GAIN_PIN,
	input wire logic I_GAIN_ASSIGNED,
	input wire pgss_loop_t I_LOOP,
	output logic O_GAIN_SECOND,
	output logic O_TICK
);
	// magnitude of a signed quantity, saturating is not needed at 32 bits
	function automatic logic [31:0] mag(input logic signed [31:0] v);
		mag = v[31] ? 32'(-v) : 32'(v);
	endfunction : mag
	// clamp a write to a parameter maximum
	function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] mx);
		clamp = (v > {16'h0000, mx}) ? mx : v[15:0];
	endfunction : clamp

	logic [3:0] mode_ff; // switching condition
	logic [15:0] delay_ff; // return delay in control cycles
	logic [15:0] level_ff; // trigger level
	logic [15:0] hyst_ff; // hysteresis as written
	logic pready_ff; // access phase answer
	logic [31:0] prdata_ff; // captured read data
	logic pslverr_ff; // unmapped address flag
	logic pin_s1_ff; // first sync stage, read only by stage two
	logic pin_s2_ff; // synchronised gain input
	logic [31:0] tick_cnt_ff; // control cycle divider
	logic tick_ff; // one-cycle control strobe
	logic [15:0] ret_cnt_ff; // elapsed qualifying cycles
	pgss_gs_t state_ff; // current gain state
	logic gain_ff; // registered gain output
	logic [15:0] eff_hyst; // hysteresis after level clamp
	logic [31:0] lo_thr; // return threshold
	logic [31:0] hi_thr; // entry threshold
	logic enter; // condition to take second gain
	logic ret_ok; // condition to go back to first gain
	logic delayed; // mode uses the return delay
	logic valid; // mode applies under current loop
	logic force_gain; // fixed or input driven choice
	logic forced; // mode is fixed, input driven or undefined
	pgss_gs_t nxt_state;
	logic [15:0] nxt_ret_cnt;
	pgss_ctl_t ctl;
	logic setup;
	logic [11:0] a;

	assign ctl = pgss_ctl_t'(I_CTRL_MODE);
	assign setup = I_PSEL & ~I_PENABLE;
	assign a = I_PADDR;

	// one-cycle answer: pready rises in the access phase
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= setup & ~pready_ff;
		end
	end

	// read data and error captured during setup
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (setup) begin
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			case (a)
				PGSS_OFS_MODE: prdata_ff <= {28'h000_0000, mode_ff};
				PGSS_OFS_DELAY: prdata_ff <= {16'h0000, delay_ff};
				PGSS_OFS_LEVEL: prdata_ff <= {16'h0000, level_ff};
				PGSS_OFS_HYST: prdata_ff <= {16'h0000, hyst_ff};
				PGSS_OFS_STAT: begin
					prdata_ff[PGSS_ST_GAIN] <= gain_ff;
					prdata_ff[PGSS_ST_CNT +: 16] <= ret_cnt_ff;
				end
				default: pslverr_ff <= 1'b1; // unmapped answers with an error
			endcase
		end else if (!I_PSEL) begin
			pslverr_ff <= 1'b0;
		end
	end

	// parameter writes take effect in the access cycle
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			mode_ff <= PGSS_MODE_RST;
			delay_ff <= PGSS_DELAY_RST;
			level_ff <= PGSS_LEVEL_RST;
			hyst_ff <= PGSS_HYST_RST;
		end else if (I_PSEL & I_PENABLE & pready_ff & I_PWRITE) begin
			case (a)
				PGSS_OFS_MODE: begin
					// an undefined condition is ignored, the old one stays
					if (I_PWDATA <= {28'h000_0000, PGSS_MODE_MAX}) begin
						mode_ff <= I_PWDATA[3:0];
					end
				end
				PGSS_OFS_DELAY: delay_ff <= clamp(I_PWDATA, PGSS_DELAY_MAX);
				PGSS_OFS_LEVEL: level_ff <= clamp(I_PWDATA, PGSS_LEVEL_MAX);
				PGSS_OFS_HYST: hyst_ff <= clamp(I_PWDATA, PGSS_LEVEL_MAX);
				default: ;
			endcase
		end
	end

	// gain input pin crosses into the clock domain
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
		end else begin
			pin_s1_ff <= I_GAIN_PIN;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			tick_cnt_ff <= 32'h0000_0000;
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff >= 32'(TICK_CYC - 1)) begin
			tick_cnt_ff <= 32'h0000_0000;
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
			tick_ff <= 1'b0;
		end
	end

	// thresholds; software should keep level above hysteresis anyway
	always_comb begin
		eff_hyst = (level_ff < hyst_ff) ? level_ff : hyst_ff;
		lo_thr = {16'h0000, level_ff - eff_hyst};
		hi_thr = {16'h0000, level_ff};
	end

	// entry and return conditions per switching mode
	always_comb begin
		enter = 1'b0;
		ret_ok = 1'b0;
		delayed = 1'b1;
		valid = (ctl == PGSS_CTL_POS) | (ctl == PGSS_CTL_FULL);
		forced = 1'b0;
		force_gain = 1'b0;
		case (mode_ff)
			PGSS_M_FIX1: begin
				forced = 1'b1;
				delayed = 1'b0;
			end
			PGSS_M_FIX2: begin
				forced = 1'b1;
				force_gain = 1'b1;
				delayed = 1'b0;
			end
			PGSS_M_INPUT: begin
				forced = 1'b1;
				delayed = 1'b0;
				force_gain = I_GAIN_ASSIGNED & pin_s2_ff;
			end
			PGSS_M_TORQUE: begin
				valid = 1'b1;
				enter = mag(I_LOOP.torque_cmd) > lo_thr;
				ret_ok = mag(I_LOOP.torque_cmd) < lo_thr;
			end
			// speed command variation, velocity loop only
			PGSS_M_SPDVAR: begin
				valid = (ctl == PGSS_CTL_VEL);
				enter = mag(I_LOOP.spd_cmd_var) > (hi_thr + {16'h0000, eff_hyst});
				ret_ok = mag(I_LOOP.spd_cmd_var) < lo_thr;
			end
			PGSS_M_SPDCMD: begin
				valid = (ctl != PGSS_CTL_TRQ);
				enter = mag(I_LOOP.spd_cmd) > hi_thr;
				ret_ok = mag(I_LOOP.spd_cmd) < lo_thr;
			end
			// deviation arrives in encoder or scale counts per loop
			PGSS_M_POSDEV: begin
				enter = mag(I_LOOP.pos_dev) > hi_thr;
				ret_ok = mag(I_LOOP.pos_dev) < lo_thr;
			end
			PGSS_M_POSCMD: begin
				enter = I_LOOP.pos_cmd_nz;
				ret_ok = ~I_LOOP.pos_cmd_nz;
			end
			PGSS_M_INPOS: begin
				enter = ~I_LOOP.pos_done;
				ret_ok = I_LOOP.pos_done;
			end
			PGSS_M_ACTSPD: begin
				enter = mag(I_LOOP.act_spd) > hi_thr;
				ret_ok = mag(I_LOOP.act_spd) < lo_thr;
			end
			// command present, return needs slow motor too
			PGSS_M_CMDSPD: begin
				enter = I_LOOP.pos_cmd_nz;
				ret_ok = ~I_LOOP.pos_cmd_nz & (mag(I_LOOP.act_spd) < lo_thr);
			end
			default: begin
				forced = 1'b1;
				delayed = 1'b0;
			end
		endcase
	end

	// next gain state, evaluated once per control cycle
	always_comb begin
		nxt_state = state_ff;
		nxt_ret_cnt = ret_cnt_ff;
		if (forced) begin
			nxt_state = force_gain ? PGSS_GS_SECOND : PGSS_GS_FIRST;
			nxt_ret_cnt = 16'h0000;
		end else if (!valid) begin
			// outside its loop a mode holds first gain
			nxt_state = PGSS_GS_FIRST;
			nxt_ret_cnt = 16'h0000;
		end else begin
			case (state_ff)
				PGSS_GS_FIRST: begin
					nxt_ret_cnt = 16'h0000;
					if (enter) begin
						nxt_state = PGSS_GS_SECOND;
					end
				end
				PGSS_GS_SECOND: begin
					if (!ret_ok) begin
						nxt_ret_cnt = 16'h0000;
					// return once the delay has elapsed
					end else if (ret_cnt_ff >= delay_ff) begin
						nxt_state = PGSS_GS_FIRST;
						nxt_ret_cnt = 16'h0000;
					end else begin
						nxt_ret_cnt = ret_cnt_ff + 16'h0001;
					end
				end
				default: begin
					nxt_state = PGSS_GS_FIRST;
					nxt_ret_cnt = 16'h0000;
				end
			endcase
		end
	end

	// state moves only on the control strobe
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state_ff <= PGSS_GS_FIRST;
			ret_cnt_ff <= 16'h0000;
			gain_ff <= 1'b0;
		end else if (tick_ff) begin
			state_ff <= nxt_state;
			ret_cnt_ff <= nxt_ret_cnt;
			gain_ff <= (nxt_state == PGSS_GS_SECOND);
		end
	end

	assign O_PREADY = pready_ff;
	assign O_PRDATA = prdata_ff;
	assign O_PSLVERR = pslverr_ff;
	assign O_GAIN_SECOND = gain_ff;
	assign O_TICK = tick_ff;

	a_fixed_first_gain: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff == PGSS_M_FIX1) |=> !gain_ff)
		else $error("mode 0 did not hold first gain");
	a_fixed_second_gain: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff == PGSS_M_FIX2) |=> gain_ff)
		else $error("mode 1 did not hold second gain");
	a_unassigned_input_first: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff == PGSS_M_INPUT && !I_GAIN_ASSIGNED) |=> !gain_ff)
		else $error("unassigned gain input left first gain");
	a_velocity_only_mode: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff == PGSS_M_SPDVAR && ctl != PGSS_CTL_VEL) |=> !gain_ff)
		else $error("mode 4 acted outside velocity control");
	a_poscmd_enters_second: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff == PGSS_M_POSCMD && ctl == PGSS_CTL_POS
		&& I_LOOP.pos_cmd_nz) |=> gain_ff)
		else $error("position command did not select second gain");
	a_hyst_clamped_level: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(hyst_ff > level_ff) ? (eff_hyst == level_ff) : (eff_hyst == hyst_ff))
		else $error("hysteresis not clamped to level");
	a_param_ranges: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		level_ff <= PGSS_LEVEL_MAX && hyst_ff <= PGSS_LEVEL_MAX && delay_ff <= PGSS_DELAY_MAX)
		else $error("parameter outside its range");
	a_count_restarts: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && !forced && valid && state_ff == PGSS_GS_SECOND && !ret_ok)
		|=> ret_cnt_ff == 16'h0000 && gain_ff)
		else $error("return count not restarted");
	a_return_after_delay: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		($fell(gain_ff) && delayed && $past(valid)) |-> $past(ret_cnt_ff) >= $past(delay_ff))
		else $error("returned to first gain before the delay");
	a_change_on_tick: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		$changed(gain_ff) |-> $past(tick_ff))
		else $error("gain changed outside a control cycle");
	a_apb_one_wait: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(I_PSEL && !I_PENABLE) |=> pready_ff)
		else $error("apb answer not in the access phase");
	// input, threshold and loop checks on the decision taken at each strobe
	a_input_follows_pin: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff == PGSS_M_INPUT && I_GAIN_ASSIGNED) |=> gain_ff == $past(pin_s2_ff))
		else $error("mode 2 did not follow the gain input");
	a_torque_enters_second: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff == PGSS_M_TORQUE && mag(I_LOOP.torque_cmd) > lo_thr) |=> gain_ff)
		else $error("large torque did not select second gain");
	a_invalid_loop_first: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff >= PGSS_M_POSDEV && mode_ff <= PGSS_M_CMDSPD
		&& (ctl == PGSS_CTL_VEL || ctl == PGSS_CTL_TRQ)) |=> !gain_ff)
		else $error("position loop mode acted outside its loops");
	a_inpos_enters_second: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && mode_ff == PGSS_M_INPOS && valid && !I_LOOP.pos_done) |=> gain_ff)
		else $error("incomplete positioning did not select second gain");
	a_return_when_due: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
		(tick_ff && !forced && valid && state_ff == PGSS_GS_SECOND && ret_ok
		&& ret_cnt_ff >= delay_ff) |=> !gain_ff)
		else $error("second gain held past the return delay");
endmodule : pgss_selector
`default_nettype wire

// *** tb/pgss_loop_model.sv ***
// control loop model feeding the selector's loop quantities
`timescale 1ns/100ps
`default_nettype none
module pgss_loop_model import pgss_pkg::*; (
	input wire logic signed [31:0] i_mag,
	input wire logic i_nz,
	input wire logic i_done,
	output var pgss_loop_t o_loop
);
	// one magnitude for every quantity, signs mixed so only abs may matter
	// deviation is already in the counts of whichever loop is active
	assign o_loop = '{torque_cmd: i_mag, spd_cmd_var: -i_mag, spd_cmd: i_mag,
		pos_dev: -i_mag, act_spd: i_mag, pos_cmd_nz: i_nz, pos_done: i_done};
endmodule : pgss_loop_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the position gain switch selector
`timescale 1ns/100ps
`default_nettype none
module tb_top import pgss_pkg::*;;
	localparam int TK = 20; // short control cycle keeps the run brief
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, pin = 0, asg = 0, nz = 0, dn = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
	logic [1:0] ctl = 2'h0;
	logic signed [31:0] mag = 32'sh0000_0000;
	logic err, g, pready, pslverr, gsec, tick;
	pgss_loop_t loop;
	int error_cnt = 0, num_checks = 0, seed = 8490, cyc = 0, lvl, hys, dly, eg, ec, tgap;
	// register table: offset, reset value, write value, value kept
	logic [11:0] ofs[4] = '{PGSS_OFS_MODE, PGSS_OFS_DELAY, PGSS_OFS_LEVEL, PGSS_OFS_HYST};
	logic [31:0] rstv[4] = '{32'h0000_0000, 32'h0000_0032, 32'h0000_0032, 32'h0000_0021};
	logic [31:0] wv[4] = '{32'h0000_000F, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF};
	logic [31:0] kv[4] = '{32'h0000_0000, 32'h0000_2710, 32'h0000_4E20, 32'h0000_4E20};
	// loops per pass and which modes give second gain with all triggers high
	pgss_ctl_t ctls[3] = '{PGSS_CTL_TRQ, PGSS_CTL_VEL, PGSS_CTL_FULL};
	logic [10:0] masks[3] = '{11'h00E, 11'h03E, 11'h7EE};
	int rm[6] = '{5, 6, 9, 7, 8, 10};

	pgss_loop_model model_u (.i_mag(mag), .i_nz(nz), .i_done(dn), .o_loop(loop));
	pgss_selector #(.TICK_CYC(TK)) dut_u (.I_MCLK(clk), .I_NRST(nrst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CTRL_MODE(ctl),
		.I_GAIN_PIN(pin), .I_GAIN_ASSIGNED(asg), .I_LOOP(loop), .O_GAIN_SECOND(gsec),
		.O_TICK(tick));

	// 200 MHz clock
	always #2.5 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one apb transfer; ready, read data and error are taken at one rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// values read right at the edge are those the edge sampled
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	// wait for a decision tick, then take the gain it produced
	task automatic tick_gain();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 100);
		@(negedge clk);
		g = gsec;
	endtask : tick_gain

	// expected gain after one tick in the triggered modes 5 to 10 under the position loop
	function automatic void ref_tick(input int m);
		int a, lo, en, rt;
		a = (mag < 0) ? -mag : mag;
		lo = lvl - ((hys > lvl) ? lvl : hys);
		en = (m == 7 || m == 10) ? nz : (m == 8) ? !dn : (a > lvl);
		rt = (m == 7) ? !nz : (m == 8) ? dn : (m == 10) ? (!nz && a < lo) : (a < lo);
		if (eg == 0) begin
			eg = en;
			ec = 0;
		end else if (!rt) begin
			ec = 0; // broken wait starts over
		end else if (ec == dly) begin
			eg = 0;
			ec = 0;
		end else begin
			ec++;
		end
	endfunction : ref_tick

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		// reset values, then clamping and ignored mode
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ofs[i], 32'h0000_0000);
			chk("reset value", rd, rstv[i]);
			apb(1'b1, ofs[i], wv[i]);
			apb(1'b0, ofs[i], 32'h0000_0000);
			chk("range limit", rd, kv[i]);
		end
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk("unmapped error", 32'(err), 32'h0000_0001);
		// every mode under three loops, all triggers well past threshold
		apb(1'b1, PGSS_OFS_LEVEL, 32'h0000_03E8);
		apb(1'b1, PGSS_OFS_HYST, 32'h0000_0064); // level not below hysteresis
		@(posedge clk);
		mag <= 32'sh0000_1388;
		nz <= 1'b1;
		pin <= 1'b1;
		asg <= 1'b1;
		for (int c = 0; c < 3; c++) begin
			@(posedge clk);
			ctl <= ctls[c];
			for (int m = 0; m <= 10; m++) begin
				apb(1'b1, PGSS_OFS_MODE, 32'(m));
				tick_gain();
				tick_gain();
				chk("mode gain", 32'(g), 32'(masks[c][m]));
			end
		end
		// status shows second gain with a cleared count, then the strobe spacing
		apb(1'b0, PGSS_OFS_STAT, 32'h0000_0000);
		chk("status word", rd, 32'h0000_0001);
		tick_gain();
		tgap = 1;
		do begin
			@(negedge clk);
			tgap++;
		end while (tick !== 1'b1);
		chk("tick spacing", 32'(tgap), 32'(TK));
		// pin high but unassigned keeps first gain
		@(posedge clk);
		asg <= 1'b0;
		apb(1'b1, PGSS_OFS_MODE, 32'h0000_0002);
		tick_gain();
		tick_gain();
		chk("unassigned input", 32'(g), 32'h0000_0000);
		// random traffic near thresholds, hysteresis sometimes above level
		@(posedge clk);
		ctl <= PGSS_CTL_POS;
		foreach (rm[k]) begin
			lvl = 20 + ($random(seed) & 8'h7F) % 100;
			hys = ($random(seed) & 8'hFF) % 150;
			dly = $random(seed) & 3;
			apb(1'b1, PGSS_OFS_MODE, 32'h0000_0000);
			apb(1'b1, PGSS_OFS_LEVEL, 32'(lvl));
			apb(1'b1, PGSS_OFS_HYST, 32'(hys));
			apb(1'b1, PGSS_OFS_DELAY, 32'(dly));
			tick_gain();
			tick_gain();
			eg = 0;
			ec = 0;
			apb(1'b1, PGSS_OFS_MODE, 32'(rm[k]));
			repeat (30) begin
				@(posedge clk);
				mag <= 32'($random(seed) % 250);
				nz <= (($random(seed) & 3) == 0);
				dn <= $random(seed) & 1;
				tick_gain();
				ref_tick(rm[k]);
				chk("switch sequence", 32'(g), 32'(eg));
			end
		end
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
